// [rtl/rcs_reset_ctrl.v]
// Reset control sequencer: cause capture and settling timing.
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_reset_ctrl #(
  parameter SETTLE_CYCLES = `RCS_SETTLE_CYC
) (
  clk_sys,
  srst,
  rst_pin_n,
  por_active,
  supply_droop_reset,
  sw_reset_req,
  wdog_reset,
  internal_regulator_fault,
  cause_clr,
  core_rst,
  periph_rst,
  tap_rst,
  boot_fetch,
  reset_cause_record
);
  input  wire                     clk_sys;
  input  wire                     srst;
  input  wire                     rst_pin_n;
  input  wire                     por_active;
  input  wire                     supply_droop_reset;
  input  wire                     sw_reset_req;
  input  wire                     wdog_reset;
  input  wire                     internal_regulator_fault;
  input  wire [`RCS_CAUSE_W-1:0]  cause_clr;
  output wire                     core_rst;
  output wire                     periph_rst;
  output wire                     tap_rst;
  output wire                     boot_fetch;
  output wire [`RCS_CAUSE_W-1:0]  reset_cause_record;

  // Terminal counts. The integer forms are cut to the counter width on
  // purpose; the default settling count still fits with room to spare.
  localparam integer          SETTLE_LAST_I = SETTLE_CYCLES - 1;
  localparam integer          INT_LAST_I    = `RCS_INT_HOLD_CYC - 1;
  localparam [`RCS_CNT_W-1:0] SETTLE_LAST   =
    SETTLE_LAST_I[`RCS_CNT_W-1:0];
  localparam [`RCS_CNT_W-1:0] INT_LAST      =
    INT_LAST_I[`RCS_CNT_W-1:0];

  // Sequencer states, binary coded; a code outside these falls back to
  // the wait state so a disturbed register cannot lock the core out.
  localparam [2:0]            ST_WAIT       = `RCS_ST_WAIT;
  localparam [2:0]            ST_SETTLE     = `RCS_ST_SETTLE;
  localparam [2:0]            ST_INT_HOLD   = `RCS_ST_INT_HOLD;
  localparam [2:0]            ST_BOOT       = `RCS_ST_BOOT;
  localparam [2:0]            ST_RUN        = `RCS_ST_RUN;

  wire                    pin_n_s;
  reg  [2:0]              state_q;
  reg  [2:0]              state_d;
  reg  [`RCS_CNT_W-1:0]   cnt_q;
  reg  [`RCS_CNT_W-1:0]   cnt_d;
  reg                     por_done_q;
  reg                     por_done_d;
  reg                     por_seq_q;
  reg                     por_seq_d;
  reg  [`RCS_CAUSE_W-1:0] pend_q;
  reg  [`RCS_CAUSE_W-1:0] pend_d;
  reg  [`RCS_CAUSE_W-1:0] cause_q;
  reg  [`RCS_CAUSE_W-1:0] cause_d;
  reg                     core_rst_q;
  reg                     core_rst_d;
  reg                     tap_rst_q;
  reg                     tap_rst_d;
  reg                     boot_q;
  reg                     boot_d;
  reg  [`RCS_CAUSE_W-1:0] int_ev;
  reg                     por_live;

  // The pin is synchronised so the settling count starts on a clean edge.
  rcs_sync #(
    .RST_VAL (1'b0)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .din     (rst_pin_n),
    .dout    (pin_n_s)
  );

  // Internal sources that restart the core from the run state.
  always @* begin
    int_ev                    = {`RCS_CAUSE_W{1'b0}};
    int_ev[`RCS_CAUSE_DROOP]  = supply_droop_reset;
    int_ev[`RCS_CAUSE_SW]     = sw_reset_req;
    int_ev[`RCS_CAUSE_WDOG]   = wdog_reset;
    int_ev[`RCS_CAUSE_REG]    = internal_regulator_fault;
    // The detector is heeded only until the wait state is first left.
    por_live = por_active & ~por_done_q;
  end

  // Sequencer next-state logic; everything runs on the one internal
  // oscillator clock, and the settling count is scaled from its rate.
  always @* begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    por_done_d = por_done_q;
    por_seq_d  = por_seq_q;
    pend_d     = pend_q;
    core_rst_d = core_rst_q;
    tap_rst_d  = tap_rst_q;
    boot_d     = 1'b0;
    case (state_q)
      ST_WAIT: begin
        core_rst_d = 1'b1;
        cnt_d      = {`RCS_CNT_W{1'b0}};
        // Leave only after the later of pin and power-on release.
        if (pin_n_s && !por_live) begin
          state_d = ST_SETTLE;
          if (!por_done_q) begin
            por_done_d = 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        core_rst_d = 1'b1;
        tap_rst_d  = 1'b0;
        // A new pin assertion restarts the wait from scratch.
        if (!pin_n_s) begin
          state_d          = ST_WAIT;
          por_seq_d        = 1'b0;
          pend_d           = {`RCS_CAUSE_W{1'b0}};
          pend_d[`RCS_CAUSE_PIN] = 1'b1;
        end else if (cnt_q == SETTLE_LAST) begin
          state_d = ST_BOOT;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_INT_HOLD: begin
        core_rst_d = 1'b1;
        if (!pin_n_s) begin
          state_d          = ST_WAIT;
          pend_d           = {`RCS_CAUSE_W{1'b0}};
          pend_d[`RCS_CAUSE_PIN] = 1'b1;
        end else if (cnt_q == INT_LAST) begin
          state_d = ST_BOOT;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_BOOT: begin
        // Core leaves reset and is told to load its vectors and fetch.
        core_rst_d = 1'b0;
        boot_d     = 1'b1;
        pend_d     = {`RCS_CAUSE_W{1'b0}};
        por_seq_d  = 1'b0;
        state_d    = ST_RUN;
      end
      ST_RUN: begin
        cnt_d = {`RCS_CNT_W{1'b0}};
        // The pin has priority over internal sources in the same cycle.
        if (!pin_n_s) begin
          core_rst_d             = 1'b1;
          pend_d                 = {`RCS_CAUSE_W{1'b0}};
          pend_d[`RCS_CAUSE_PIN] = 1'b1;
          state_d                = ST_WAIT;
        end else if (|int_ev) begin
          core_rst_d = 1'b1;
          pend_d     = int_ev;
          state_d    = ST_INT_HOLD;
        end
      end
      default: begin
        state_d    = ST_WAIT;
        core_rst_d = 1'b1;
      end
    endcase
  end

  // Cause record update: recorded as the sequence completes. Pin causes
  // wipe the rest; others accumulate. A set beats a clear in one cycle.
  always @* begin
    cause_d = cause_q & ~cause_clr;
    if (state_q == ST_BOOT) begin
      if (pend_q[`RCS_CAUSE_PIN] && !por_seq_q) begin
        cause_d = {`RCS_CAUSE_W{1'b0}};
        cause_d[`RCS_CAUSE_PIN] = 1'b1;
      end else begin
        cause_d = cause_d | pend_q;
        if (por_seq_q) begin
          cause_d[`RCS_CAUSE_POR] = 1'b1;
        end
      end
    end
  end

  // State registers. The power-up state waits with the test port also held,
  // since only power-on may reset the test port.
  always @(posedge clk_sys) begin
    if (srst) begin
      state_q    <= ST_WAIT;
      cnt_q      <= {`RCS_CNT_W{1'b0}};
      por_done_q <= 1'b0;
      por_seq_q  <= 1'b1;
      pend_q     <= {`RCS_CAUSE_W{1'b0}};
      cause_q    <= `RCS_CAUSE_RST;
      core_rst_q <= 1'b1;
      tap_rst_q  <= 1'b1;
      boot_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      por_done_q <= por_done_d;
      por_seq_q  <= por_seq_d;
      pend_q     <= pend_d;
      cause_q    <= cause_d;
      core_rst_q <= core_rst_d;
      tap_rst_q  <= tap_rst_d;
      boot_q     <= boot_d;
    end
  end

  // Core and peripherals share one reset; the test port has its own.
  assign core_rst           = core_rst_q;
  assign periph_rst         = core_rst_q;
  assign tap_rst            = tap_rst_q;
  assign boot_fetch         = boot_q;
  assign reset_cause_record = cause_q;
endmodule

// [common/rcs_defs.vh]
// Constants for the reset control sequencer.
// Functional notes
// - Six reset causes are accepted: pin, power-on, supply droop, software, watchdog and regulator fault.
// - When a reset sequence completes, its cause is recorded in the reset cause record.
// - Cause bits are sticky and survive later reset sequences that are not pin-caused.
// - A pin-caused reset clears every other cause bit and leaves only the pin bit set.
// - Pin and power-on sequencing is timed by a count derived from the oscillator rate.
// - Reset processing runs entirely on the single internal oscillator clock.
// - The pin resets the core and peripherals but never the test access port.
// - After the pin is released a 15-30 ms settling count runs with internal reset held.
// - On release of internal reset the core is told to load stack pointer and program counter and fetch.
// - The power-on detector pulse starts the power-on sequence; the code starts it on srst, and por_active only holds the first wait state.
// - Power-on sequencing waits for the later of pin release and power-on release.
// - After both are inactive, internal reset is held through the settling count.
// - The power-on source acts only on the first power-up and is ignored afterwards.
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH

// Cause record bit positions.
`define RCS_CAUSE_W        6
`define RCS_CAUSE_PIN      0
`define RCS_CAUSE_POR      1
`define RCS_CAUSE_DROOP    2
`define RCS_CAUSE_SW       3
`define RCS_CAUSE_WDOG     4
`define RCS_CAUSE_REG      5
`define RCS_CAUSE_RST      6'h00

// Timing: clock rate and the least settling time.
`define RCS_CLK_KHZ        200000
`define RCS_SETTLE_MS      15
`define RCS_SETTLE_CYC     (`RCS_SETTLE_MS * `RCS_CLK_KHZ)
`define RCS_CNT_W          22
`define RCS_INT_HOLD_CYC   16

// Sequencer states.
`define RCS_ST_WAIT        3'h0
`define RCS_ST_SETTLE      3'h1
`define RCS_ST_INT_HOLD    3'h2
`define RCS_ST_BOOT        3'h3
`define RCS_ST_RUN         3'h4

`endif

// [rtl/rcs_sync.v]
// Two-flop level synchroniser for asynchronous reset inputs.
`timescale 1ns/1ps
module rcs_sync #(
  parameter RST_VAL = 1'b1
) (
  clk_sys,
  srst,
  din,
  dout
);
  input  wire clk_sys;
  input  wire srst;
  input  wire din;
  output wire dout;

  reg meta_q;
  reg sync_q;

  // The first flop is read only by the second to keep metastability contained.
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// [tb/rcs_pin_driver.sv]
// Board reset driver model on the active-low reset pin.
`timescale 1ns/1ps
module rcs_pin_driver (
  input  wire logic clk_sys,
  output wire logic rst_pin_n
);
  logic lo_q = 1'b1;
  // The supervisor holds reset at power-up; released, the pull-up wins.
  assign rst_pin_n = lo_q ? 1'b0 : 1'b1;
  // Assert or release the pin just after a clock edge.
  task drive(input bit v);
    @(posedge clk_sys);
    lo_q <= v;
  endtask
endmodule

// [tb/rcs_checker.sv]
// Port-level assertions for the reset control sequencer.
`timescale 1ns/1ps
module rcs_checker #(
  parameter SETTLE_CYCLES = 20
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       rst_pin_n,
  input wire logic       wdog_reset,
  input wire logic [5:0] cause_clr,
  input wire logic       core_rst,
  input wire logic       periph_rst,
  input wire logic       tap_rst,
  input wire logic       boot_fetch,
  input wire logic [5:0] reset_cause_record
);
  // Wide enough that the full-length settling count cannot saturate it.
  logic [31:0] cnt_q;
  logic       pin_ep_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Edges since the pin was last low; the flag marks a pin-led episode.
  always_ff @(posedge clk_sys) begin
    if (srst || !rst_pin_n) cnt_q <= 32'h00000000;
    else if (cnt_q != 32'hFFFFFFFF) cnt_q <= cnt_q + 32'h00000001;
    if (srst) pin_ep_q <= 1'b0;
    else if (!rst_pin_n) pin_ep_q <= 1'b1;
    else if (!core_rst) pin_ep_q <= 1'b0;
  end
  AST_PERIPH: assert property (periph_rst == core_rst)
    else $error("peripheral reset differs from core reset");
  AST_BOOT: assert property (boot_fetch |-> !core_rst && $past(core_rst))
    else $error("boot fetch not at core reset release");
  AST_BOOT_ONE: assert property (boot_fetch |=> !boot_fetch)
    else $error("boot fetch longer than one cycle");
  AST_PIN_RST: assert property (!rst_pin_n |-> ##[0:4] core_rst)
    else $error("pin low without core reset");
  AST_SETTLE_MIN: assert property ($fell(core_rst) && pin_ep_q |-> cnt_q >= SETTLE_CYCLES)
    else $error("core released before settling count");
  AST_SETTLE_MAX: assert property (pin_ep_q && cnt_q == 32'(SETTLE_CYCLES + 8) |-> !core_rst)
    else $error("core held too long after pin release");
  AST_CAUSE_SET: assert property (|(reset_cause_record & ~$past(reset_cause_record)) |-> boot_fetch)
    else $error("cause bit set outside boot");
  AST_STICKY: assert property (|($past(reset_cause_record) & ~reset_cause_record) |-> boot_fetch || |$past(cause_clr))
    else $error("cause bit lost without clear");
  AST_WDOG: assert property ($rose(wdog_reset) && !core_rst && rst_pin_n |=> core_rst)
    else $error("watchdog event not taken");
  AST_TAP: assert property (!tap_rst |=> !tap_rst)
    else $error("test port reset after power-up");
endmodule
bind rcs_reset_ctrl rcs_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .rst_pin_n(rst_pin_n),
  .wdog_reset(wdog_reset), .cause_clr(cause_clr), .core_rst(core_rst),
  .periph_rst(periph_rst), .tap_rst(tap_rst), .boot_fetch(boot_fetch),
  .reset_cause_record(reset_cause_record));

// [tb/tb_top.sv]
// Self-checking bench for the reset control sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  localparam int SET_CYC = 20;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       por_active = 1'b1;
  logic [3:0] ev = 4'h0;
  logic [5:0] cause_clr = 6'h00;
  logic [5:0] exp_c;
  wire        rst_pin_n, core_rst, periph_rst, tap_rst, boot_fetch;
  wire  [5:0] cause;
  int         bad_count = 0;
  int         num_checks = 0;
  int         n;
  // A short settling count keeps the run brief.
  always #2.5 clk_sys = ~clk_sys;
  rcs_pin_driver u_pin (.clk_sys(clk_sys), .rst_pin_n(rst_pin_n));
  rcs_reset_ctrl #(.SETTLE_CYCLES(SET_CYC)) dut (
    .clk_sys(clk_sys), .srst(srst), .rst_pin_n(rst_pin_n),
    .por_active(por_active), .supply_droop_reset(ev[0]),
    .sw_reset_req(ev[1]), .wdog_reset(ev[2]),
    .internal_regulator_fault(ev[3]), .cause_clr(cause_clr),
    .core_rst(core_rst), .periph_rst(periph_rst), .tap_rst(tap_rst),
    .boot_fetch(boot_fetch), .reset_cause_record(cause));
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Count cycles until the boot pulse; a lost pulse ends the run.
  task wait_boot(output int k);
    k = 0;
    while (boot_fetch !== 1'b1) begin
      @(posedge clk_sys); #1; k++;
      if (k > 400) begin
        bad_count++;
        $display("[FAIL] boot_fetch exp 1 got 0");
        stop_test();
      end
    end
  endtask
  // Power-up with the pin released after the detector.
  task t_por();
    repeat (5) @(posedge clk_sys);
    por_active <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 `CHK("held", 1'b1, core_rst)
    `CHK("tap held", 1'b1, tap_rst)
    u_pin.drive(1'b0);
    wait_boot(n);
    `CHK("por settle", 1'b1, n >= SET_CYC)
    `CHK("por settle max", 1'b1, n <= 2 * SET_CYC)
    `CHK("por cause", 6'h02, cause)
    `CHK("tap", 1'b0, tap_rst)
    exp_c = 6'h02;
  endtask
  // Each internal cause in turn; bits accumulate.
  task t_int();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) ev[i] <= 1'b1;
      @(posedge clk_sys) ev[i] <= 1'b0;
      wait_boot(n);
      exp_c = exp_c | (6'h04 << i);
      `CHK("int cause", exp_c, cause)
      `CHK("int hold", 1'b1, n >= 16)
    end
  endtask
  // Pin reset clears the other causes and spares the test port.
  task t_pin();
    u_pin.drive(1'b1);
    repeat (4) @(posedge clk_sys);
    #1 `CHK("pin core", 1'b1, core_rst)
    `CHK("pin periph", 1'b1, periph_rst)
    u_pin.drive(1'b0);
    wait_boot(n);
    `CHK("pin settle", 1'b1, n >= SET_CYC)
    `CHK("pin settle max", 1'b1, n <= 2 * SET_CYC)
    `CHK("pin cause", 6'h01, cause)
    `CHK("tap pin", 1'b0, tap_rst)
  endtask
  // A late detector level must not hold a pin reset, then clear the record.
  task t_late();
    @(posedge clk_sys) por_active <= 1'b1;
    u_pin.drive(1'b1);
    repeat (4) @(posedge clk_sys);
    u_pin.drive(1'b0);
    wait_boot(n);
    `CHK("late por boot", 1'b1, n <= 2 * SET_CYC)
    `CHK("late por cause", 6'h01, cause)
    @(posedge clk_sys) por_active <= 1'b0;
    cause_clr <= 6'h01;
    @(posedge clk_sys) cause_clr <= 6'h00;
    repeat (30) @(posedge clk_sys);
    #1 `CHK("late por", 1'b0, core_rst)
    `CHK("cleared", 6'h00, cause)
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_por();
    t_int();
    t_pin();
    t_late();
    stop_test();
  end
endmodule
